//--- design/ugi_top.sv
// USB device global interrupt flags, enables and APB register slave.
// How it works
// - Filtered line activity after suspend sets wake flag.
// - Wake flag rises even with clock frozen.
// - Suspend flag setting clears the wake flag.
// - Host end-of-resume sets its own flag.
// - Sent upstream resume sets its own flag.
// - Endpoint flags mirror endpoint pending interrupts.
// - DMA flag set by channel, cleared by source.
// - Interrupt is OR of flags ANDed with enables.
// - Flag-set ones force the matching bus flags.
// - Enables read-only; suspend enable via set/clear.
// - Frame enable set and cleared by strobes.
// - Three milliseconds idle J sets suspend flag.
// - Wake flag setting clears the suspend flag.
// - Start-of-frame sets flag, updates frame number.
`timescale 1ns/1ps
`include "ugi_defines.svh"

module ugi_top #(
    parameter int BUS_IDLE_FLAG_CYC = `UGI_BUS_IDLE_FLAG_CYC
) (
    // APB clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // USB line sense, asynchronous
    input  wire logic              line_idle_j,
    // USB controller core events
    input  wire ugi_pkg::ugi_evt_t usb_evt,
    // Controls and interrupt
    output logic                   clock_freeze,
    output logic                   usb_irq
);

    // ****************************************
    // State
    // ****************************************
    logic [31:0]        flags_q;
    logic [31:0]        flags_d;
    logic [31:0]        en_q;
    logic [31:0]        en_d;
    logic               frz_q;
    logic [10:0]        fnum_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic               irq_q;
    logic               idle_s1_q;
    logic               idle_s2_q;
    logic [15:0]        idle_cnt_q;
    logic [1:0]         filt_cnt_q;
    ugi_pkg::ugi_line_t line_q;

    // ****************************************
    // Bus decode
    // ****************************************
    wire        acc     = psel & penable;
    wire        done    = acc & pready_q;
    wire        wr      = done & pwrite;
    wire        aligned = (paddr[1:0] == 2'h0);
    wire        hit_flg = aligned & (paddr == `UGI_OFF_FLAGS);
    wire        hit_fcl = aligned & (paddr == `UGI_OFF_FLAG_CLR);
    wire        hit_fst = aligned & (paddr == `UGI_OFF_FLAG_SET);
    wire        hit_en  = aligned & (paddr == `UGI_OFF_EN);
    wire        hit_ecl = aligned & (paddr == `UGI_OFF_EN_CLR);
    wire        hit_est = aligned & (paddr == `UGI_OFF_EN_SET);
    wire        hit_ctl = aligned & (paddr == `UGI_OFF_CTRL);
    wire        hit_fn  = aligned & (paddr == `UGI_OFF_FNUM);
    wire        mapped  = hit_flg | hit_fcl | hit_fst | hit_en
                        | hit_ecl | hit_est | hit_ctl | hit_fn;

    // Write strobes are masked so reserved bits never reach a flag.
    wire [31:0] sw_clr  = (wr & hit_fcl) ? (pwdata & `UGI_M_FLAG_CLR) : 32'h0;
    wire [31:0] sw_set  = (wr & hit_fst) ? (pwdata & `UGI_M_FLAG_SET) : 32'h0;
    wire [31:0] en_clr  = (wr & hit_ecl) ? (pwdata & `UGI_M_EN) : 32'h0;
    wire [31:0] en_set  = (wr & hit_est) ? (pwdata & `UGI_M_EN) : 32'h0;

    // Strobe registers carry no state, so they read back as zero.
    wire [31:0] rdata   = hit_flg ? flags_q
                        : hit_en  ? en_q
                        : hit_ctl ? {31'h0, frz_q}
                        : hit_fn  ? {21'h0, fnum_q}
                        : 32'h0;

    // ****************************************
    // Line monitor
    // ****************************************
    // The core only produces events while its clock runs.
    wire        run      = ~frz_q;
    wire        idle_hit = (idle_cnt_q == BUS_IDLE_FLAG_CYC[15:0]);
    wire        bus_idle_flag_hw  = (line_q == ugi_pkg::LN_ACTIVE) & idle_s2_q & run
                         & (idle_cnt_q == BUS_IDLE_FLAG_CYC[15:0] - 16'h1);
    // Wake detection uses the free pclk, not the frozen core clock.
    wire        wake_hw  = (line_q == ugi_pkg::LN_BUS_IDLE_FLAG) & ~idle_s2_q
                         & (filt_cnt_q == `UGI_WAKE_FILT - 2'h1);

    // Two flops on the line sense; only the second is read.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_s1_q <= 1'b0;
            idle_s2_q <= 1'b0;
        end
        else
        begin
            idle_s1_q <= line_idle_j;
            idle_s2_q <= idle_s1_q;
        end
    end

    // Idle time counter; it saturates so suspend is signalled once.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_cnt_q <= 16'h0;
        else if (!idle_s2_q || line_q == ugi_pkg::LN_BUS_IDLE_FLAG)
            idle_cnt_q <= 16'h0;
        else if (run && !idle_hit)
            idle_cnt_q <= idle_cnt_q + 16'h1;
    end

    // Glitch filter: activity must last several cycles to wake.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            filt_cnt_q <= 2'h0;
        else if (idle_s2_q || line_q == ugi_pkg::LN_ACTIVE)
            filt_cnt_q <= 2'h0;
        else if (filt_cnt_q != `UGI_WAKE_FILT)
            filt_cnt_q <= filt_cnt_q + 2'h1;
    end

    // Own upstream resume leaves suspend but raises no wake flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_q <= ugi_pkg::LN_ACTIVE;
        else
        begin
            case (line_q)
                ugi_pkg::LN_ACTIVE:
                    if (bus_idle_flag_hw)
                        line_q <= ugi_pkg::LN_BUS_IDLE_FLAG;
                ugi_pkg::LN_BUS_IDLE_FLAG:
                    if (wake_hw || (run && usb_evt.remote_resume_sent))
                        line_q <= ugi_pkg::LN_ACTIVE;
                default:
                    line_q <= ugi_pkg::LN_ACTIVE;
            endcase
        end
    end

    // ****************************************
    // Flag update
    // ****************************************
    wire        sof_hw   = run & usb_evt.sof;
    wire [6:1]  dma_set  = usb_evt.dma_irq & {6{run}};
    wire [6:1]  dma_clr  = usb_evt.dma_src_clr & {6{run}};
    wire        bus_idle_flag_any = bus_idle_flag_hw | sw_set[`UGI_B_BUS_IDLE_FLAG];
    wire        wake_any = wake_hw | sw_set[`UGI_B_WAKE];

    // Hardware set sources, laid out like the flag register.
    wire [31:0] hw_set   = {1'b0, dma_set, 18'h0,
                            run & usb_evt.remote_resume_sent,
                            run & usb_evt.resume_end,
                            wake_hw,
                            run & usb_evt.bus_reset_end,
                            sof_hw,
                            1'b0,
                            bus_idle_flag_hw};

    // Automatic clears: suspend and wake knock each other out.
    wire [31:0] hw_clr   = {1'b0, dma_clr, 18'h0, 2'h0,
                            bus_idle_flag_any,
                            3'h0,
                            wake_any};

    wire [31:0] clr_all  = hw_clr | sw_clr;
    wire [31:0] set_all  = hw_set | sw_set;
    // Set is applied after clear so a coincident event survives.
    wire [31:0] flg_next = (flags_q & ~clr_all) | set_all;
    // Endpoint flags follow the endpoint sources; held while frozen.
    wire [6:0]  ep_next  = run ? usb_evt.ep_irq : flags_q[18:12];

    assign flags_d = {flg_next[31:19], ep_next, flg_next[11:0]};
    // Enables change only through the strobe registers.
    assign en_d    = (en_q & ~en_clr) | en_set;

    // Flag and enable registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_q <= `UGI_RST_FLAGS;
            en_q    <= `UGI_RST_EN;
        end
        else
        begin
            flags_q <= flags_d;
            en_q    <= en_d;
        end
    end

    // Control bit and frame number.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frz_q  <= `UGI_RST_FRZ;
            fnum_q <= `UGI_RST_FNUM;
        end
        else
        begin
            if (wr && hit_ctl)
                frz_q <= pwdata[`UGI_B_CTRL_FRZ];
            if (sof_hw)
                fnum_q <= usb_evt.frame_num;
        end
    end

    // ****************************************
    // Interrupt output
    // ****************************************
    // Registered so the pin never glitches during flag updates.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(flags_q & en_q);
    end

    // ****************************************
    // APB answer
    // ****************************************
    // One wait state buys a registered read path and error flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end
        else
        begin
            pready_q  <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~mapped;
            prdata_q  <= (acc & ~pready_q & ~pwrite) ? rdata : 32'h0;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign clock_freeze = frz_q;
    assign usb_irq      = irq_q;

endmodule // ugi_top

//--- design/ugi_defines.svh
// Offsets, field positions, reset values and timing counts of the USB global flag block.
`ifndef UGI_DEFINES_SVH
`define UGI_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define UGI_OFF_FLAGS    8'h04
`define UGI_OFF_FLAG_CLR 8'h08
`define UGI_OFF_FLAG_SET 8'h0c
`define UGI_OFF_EN       8'h10
`define UGI_OFF_EN_CLR   8'h14
`define UGI_OFF_EN_SET   8'h18
`define UGI_OFF_CTRL     8'h1c
`define UGI_OFF_FNUM     8'h20

// ****************************************
// Field positions and write masks
// ****************************************
`define UGI_B_BUS_IDLE_FLAG       0
`define UGI_B_SOF        2
`define UGI_B_BUS_RESET_END_FLAG      3
`define UGI_B_WAKE       4
`define UGI_B_RESUME_END_FLAG      5
`define UGI_B_REMOTE_RESUME_FLAG      6
`define UGI_B_CTRL_FRZ   0
`define UGI_M_FLAG_CLR   32'h0000_007d
`define UGI_M_FLAG_SET   32'h7e00_007d
`define UGI_M_EN         32'h7e07_f07d

// ****************************************
// Reset values
// ****************************************
`define UGI_RST_FLAGS    32'h0000_0000
`define UGI_RST_EN       32'h0000_0000
`define UGI_RST_FRZ      1'h0
`define UGI_RST_FNUM     11'h000

// ****************************************
// Timing
// ****************************************
`define UGI_CLK_HZ       10000000
`define UGI_BUS_IDLE_FLAG_MS      3
`define UGI_BUS_IDLE_FLAG_CYC     (`UGI_BUS_IDLE_FLAG_MS * `UGI_CLK_HZ / 1000)
`define UGI_WAKE_FILT    2'h3

`endif

//--- design/ugi_pkg.sv
// Types shared by the USB global flag block.
package ugi_pkg;

    // Events from the USB controller core, all on pclk.
    typedef struct packed {
        logic        sof;
        logic [10:0] frame_num;
        logic        bus_reset_end;
        logic        resume_end;
        logic        remote_resume_sent;
        logic [6:0]  ep_irq;
        logic [6:1]  dma_irq;
        logic [6:1]  dma_src_clr;
    } ugi_evt_t;

    // Line monitor state.
    typedef enum logic [0:0] {
        LN_ACTIVE = 1'b0,
        LN_BUS_IDLE_FLAG   = 1'b1
    } ugi_line_t;

endpackage

//--- bench/ugi_chk.sv
// Port checks of the USB global flag block.
`timescale 1ns/1ps
`include "ugi_defines.svh"
module ugi_chk (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB slave side
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Line, core events and outputs
    input wire logic              line_idle_j,
    input wire ugi_pkg::ugi_evt_t usb_evt,
    input wire logic              clock_freeze,
    input wire logic              usb_irq
);
    // ********
    // Shadow state
    // ********
    logic [31:0] en_q, en_d;
    logic [6:1]  dma_q, dma_d;
    logic [10:0] fn_q, fn_d;
    logic [6:0]  ep_q;
    logic [1:0]  eps_q, eps_d;
    // Core events count only while the clock runs.
    wire go = !clock_freeze;
    wire wr_done = psel && penable && pready && pwrite;
    wire rd_done = psel && penable && pready && !pwrite;
    // Enables move only by strobes; for DMA a set beats a clear.
    assign en_d = (wr_done && paddr == 8'h18) ? en_q | (pwdata & `UGI_M_EN) :
        (wr_done && paddr == 8'h14) ? en_q & ~pwdata : en_q;
    assign dma_d = (dma_q & ~(usb_evt.dma_src_clr & {6{go}})) | (usb_evt.dma_irq & {6{go}})
        | ((wr_done && paddr == 8'h0c) ? pwdata[30:25] : 6'h00);
    assign fn_d = (usb_evt.sof && go) ? usb_evt.frame_num : fn_q;
    assign eps_d = (usb_evt.ep_irq != ep_q) ? 2'h0 : (eps_q == 2'h2) ? eps_q : eps_q + 2'h1;
    // Shadows clear with the block so no check fires just after reset.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {en_q, dma_q, fn_q, ep_q, eps_q} <= '0;
        else
            {en_q, dma_q, fn_q, ep_q, eps_q} <= {en_d, dma_d, fn_d, usb_evt.ep_irq, eps_d};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_wo_read_zero: assert property (rd_done && paddr inside {8'h08, 8'h0c, 8'h14, 8'h18}
        |-> prdata == 32'h0) else $error("strobe register read not zero");
    a_en_readback: assert property (rd_done && paddr == 8'h10 |-> prdata == en_q)
        else $error("enable register wrong");
    a_irq_masked: assert property (en_q == 32'h0 && $past(en_q) == 32'h0 |-> !usb_irq)
        else $error("irq with all enables off");
    a_irq_force: assert property (wr_done && paddr == 8'h0c && (pwdata & en_q & 32'h6c) != 0
        |-> ##2 usb_irq [*2]) else $error("forced enabled flag gave no irq");
    a_irq_clear: assert property (wr_done && paddr == 8'h08 && pwdata[6:0] == 7'h7d
        && (en_q & ~32'h7d) == 0 |-> ##2 !usb_irq) else $error("irq after clear");
    a_frame_num: assert property (rd_done && paddr == 8'h20 |-> prdata[10:0] == fn_q)
        else $error("frame number wrong");
    a_dma_flags: assert property (rd_done && paddr == 8'h04 |-> prdata[30:25] == dma_q)
        else $error("dma flags wrong");
    a_ep_mirror: assert property (rd_done && paddr == 8'h04 && go && eps_q == 2'h2
        |-> prdata[18:12] == usb_evt.ep_irq) else $error("endpoint flags wrong");
    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(usb_irq));
    c_frame: cover property (usb_evt.sof && go);
endmodule // ugi_chk

bind ugi_top ugi_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_idle_j(line_idle_j), .usb_evt(usb_evt),
    .clock_freeze(clock_freeze), .usb_irq(usb_irq));

//--- bench/ugi_usb_model.sv
// Model of the USB lines and core events feeding the flag block.
`timescale 1ns/1ps
module ugi_usb_model (
    // Clock
    input wire logic          pclk,
    // Line level and core events
    output logic              line_idle_j,
    output ugi_pkg::ugi_evt_t usb_evt
);
    ugi_pkg::ugi_evt_t base = '0;
    // Active bus and no events from time zero.
    initial
        {line_idle_j, usb_evt} = '0;
    // One-cycle pulse over held endpoint levels; a spare edge keeps drives apart.
    task automatic pulse(input ugi_pkg::ugi_evt_t e);
        usb_evt <= ugi_pkg::ugi_evt_t'(e | base);
        @(posedge pclk);
        usb_evt <= base;
        @(posedge pclk);
    endtask
    // Endpoint pending levels stay until changed.
    task automatic ep(input logic [6:0] v);
        base.ep_irq = v;
        usb_evt <= base;
        @(posedge pclk);
    endtask
    // Line idle J when 1, active when 0.
    task automatic idle(input logic v);
        line_idle_j <= v;
        @(posedge pclk);
    endtask
endmodule // ugi_usb_model

//--- bench/tb_top.sv
// Self-checking bench of the USB global flag block.
`timescale 1ns/1ps
module tb_top;
    // ********
    // Bench state
    // ********
    localparam int     SC = 20;
    logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic              pready, pslverr, line_idle_j, clock_freeze, usb_irq;
    logic [7:0]        paddr = 8'h00;
    logic [7:0]        zr [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    logic [31:0]       pwdata = 32'h0, prdata;
    logic [31:0]       ex [6];
    ugi_pkg::ugi_evt_t usb_evt, ev [6];
    int                errors = 0, checked = 0, cyc = 0;
    // A 100 ns clock.
    initial
        forever #50 pclk = ~pclk;
    // Short idle count keeps the suspend test brief.
    ugi_top #(.BUS_IDLE_FLAG_CYC(SC)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_idle_j(line_idle_j), .usb_evt(usb_evt),
        .clock_freeze(clock_freeze), .usb_irq(usb_irq));
    ugi_usb_model i_usb (.pclk(pclk), .line_idle_j(line_idle_j), .usb_evt(usb_evt));
    task automatic cmp(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    // Request held until pready is seen; only address 0x00 may answer an error.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        if (!w)
        begin
            cmp(prdata, d);
            cmp({31'h0, pslverr}, {31'h0, a == 8'h00});
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, e);
    endtask
    task automatic end_of_test(input int extra);
        errors += extra;
        $display("counts: %0d compares, %0d mismatches", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // A hang counts as a mismatch.
    always @(posedge pclk)
        if (++cyc == 3000)
            end_of_test(1);
    // Reset, then the tests in order.
    initial
    begin
        ev[0] = '{sof: 1'b1, frame_num: 11'h5a5, default: '0};
        ev[1] = '{bus_reset_end: 1'b1, default: '0};
        ev[2] = '{resume_end: 1'b1, default: '0};
        ev[3] = '{remote_resume_sent: 1'b1, default: '0};
        ev[4] = '{dma_irq: 6'h04, dma_src_clr: 6'h04, default: '0};
        ev[5] = '{dma_src_clr: 6'h3f, default: '0};
        ex = '{32'h4, 32'h8, 32'h20, 32'h40, 32'h0800_0000, 32'h0};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (zr[i]) rd(zr[i], 32'h0);
        $display("test reset done");
        wr(8'h0c, 32'h7e00_006c);
        rd(8'h04, 32'h7e00_006c);
        wr(8'h08, 32'h0);
        wr(8'h0c, 32'h0);
        rd(8'h04, 32'h7e00_006c);
        wr(8'h08, 32'h7d);
        rd(8'h04, 32'h7e00_0000);
        wr(8'h0c, 32'h10);
        wr(8'h0c, 32'h1);
        rd(8'h04, 32'h7e00_0001);
        wr(8'h0c, 32'h10);
        rd(8'h04, 32'h7e00_0010);
        i_usb.pulse(ev[5]);
        wr(8'h08, 32'h10);
        rd(8'h04, 32'h0);
        $display("test force and clear done");
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, 32'h0);
        wr(8'h18, 32'h5);
        rd(8'h10, 32'h5);
        wr(8'h14, 32'h1);
        rd(8'h10, 32'h4);
        wr(8'h0c, 32'h1);
        @(negedge pclk);
        cmp({31'h0, usb_irq}, 32'h0);
        wr(8'h0c, 32'h4);
        @(negedge pclk);
        cmp({31'h0, usb_irq}, 32'h1);
        wr(8'h08, 32'h7d);
        wr(8'h14, 32'hffff_ffff);
        @(negedge pclk);
        cmp({31'h0, usb_irq}, 32'h0);
        $display("test enables done");
        for (int i = 0; i < 6; i++)
        begin
            i_usb.pulse(ev[i]);
            rd(8'h04, ex[i]);
            wr(8'h08, 32'h7d);
        end
        rd(8'h20, 32'h5a5);
        i_usb.ep(7'h55);
        rd(8'h04, 32'h0005_5000);
        i_usb.ep(7'h00);
        rd(8'h04, 32'h0);
        $display("test events done");
        i_usb.idle(1'b1);
        repeat (SC - 6) @(posedge pclk);
        rd(8'h04, 32'h0);
        repeat (10) @(posedge pclk);
        rd(8'h04, 32'h1);
        wr(8'h1c, 32'h1);
        rd(8'h1c, 32'h1);
        i_usb.idle(1'b0);
        repeat (8) @(posedge pclk);
        rd(8'h04, 32'h10);
        wr(8'h1c, 32'h0);
        wr(8'h08, 32'h10);
        rd(8'h04, 32'h0);
        $display("test suspend and wake done");
        end_of_test(0);
    end
endmodule // tb_top
